// [rtl/sgsel_ctrl_if.sv]
// interface: request and result wires between register front end and selector core
`timescale 1ns/100ps
`default_nettype none

interface sgsel_ctrl_if;
  logic [7:0] req_vec;
  logic [7:0] remote_vec;
  logic [7:0] force_vec;
  logic [7:0] used_mask;
  logic       force_en;
  logic [2:0] active;
  logic [1:0] cause;

  modport front (
    output req_vec,
    output remote_vec,
    output force_vec,
    output used_mask,
    output force_en,
    input  active,
    input  cause
  );

  modport core (
    input  req_vec,
    input  remote_vec,
    input  force_vec,
    input  used_mask,
    input  force_en,
    output active,
    output cause
  );
endinterface

`default_nettype wire

// [rtl/sgsel_group_selector.sv]
// selector core: priority resolution and the active group register
`timescale 1ns/100ps
`default_nettype none

module sgsel_group_selector
  import sgsel_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  sgsel_ctrl_if.core ctl
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sgsel_core_st_t st_r;
  sgsel_core_st_t st_nxt;
  logic [7:0]     auto_vec;
  logic [7:0]     frc_vec;
  logic [2:0]     auto_win;
  logic [2:0]     frc_win;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    // requests for groups not in use are dropped here
    auto_vec = (ctl.req_vec | ctl.remote_vec) & ctl.used_mask;
    frc_vec  = ctl.force_vec & ctl.used_mask;
    auto_win = 3'h0;
    frc_win  = 3'h0;
    // descending scan: the lowest numbered request is written last and wins
    for (int i = SGSEL_NUM_GROUPS - 1; i >= 0; i--) begin
      if (auto_vec[i]) begin
        auto_win = 3'(i);
      end
      if (frc_vec[i]) begin
        frc_win = 3'(i);
      end
    end
    if (ctl.used_mask == SGSEL_ONLY_FIRST) begin
      // one group in use: selector idle, group 1 held
      st_nxt.active = SGSEL_ACTIVE_RST;
    end else if (ctl.force_en) begin
      // automatic inputs ignored while overriding
      if (|frc_vec) begin
        st_nxt.active = frc_win;
        st_nxt.cause  = SGSEL_CAUSE_FORCE;
      end
    end else if (|auto_vec) begin
      // levels and pulses look alike here: a level simply keeps winning
      st_nxt.active = auto_win;
      if (ctl.req_vec[auto_win]) begin
        st_nxt.cause = SGSEL_CAUSE_AUTO;
      end else begin
        st_nxt.cause = SGSEL_CAUSE_REMOTE;
      end
    end else if (!ctl.used_mask[st_r.active]) begin
      // with the override off, shrinking the set of groups must not leave a dead group active
      st_nxt.active = SGSEL_ACTIVE_RST;
      st_nxt.cause  = SGSEL_CAUSE_RESET;
    end
    // no request: last group stays
  end

  // ----------------------------------------------------------------------
  // register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.active <= SGSEL_ACTIVE_RST;
      st_r.cause  <= SGSEL_CAUSE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctl.active = st_r.active;
  assign ctl.cause  = st_r.cause;

endmodule // sgsel_group_selector

`default_nettype wire

// [rtl/sgsel_pkg.sv]
// package: constants, types and decoders shared by the setting group selector
package sgsel_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int          SGSEL_NUM_GROUPS   = 8;
  localparam int          SGSEL_ADDR_W       = 8;
  localparam int          SGSEL_DATA_W       = 32;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SGSEL_OFS_CONFIG   = 8'h00;
  localparam logic [7:0]  SGSEL_OFS_FORCE    = 8'h04;
  localparam logic [7:0]  SGSEL_OFS_REMOTE   = 8'h08;
  localparam logic [7:0]  SGSEL_OFS_STATUS   = 8'h0C;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int          SGSEL_CFG_USED_LSB = 0;
  localparam int          SGSEL_CFG_FORCE_BIT = 8;
  localparam int          SGSEL_CMD_GRP_LSB  = 0;
  localparam int          SGSEL_ST_ACT_LSB   = 0;
  localparam int          SGSEL_ST_REQ_LSB   = 8;
  localparam int          SGSEL_ST_FORCE_BIT = 16;
  localparam int          SGSEL_ST_CAUSE_LSB = 20;
  localparam int          SGSEL_ST_USED_LSB  = 24;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0]  SGSEL_USED_RST     = 3'h0;
  localparam logic        SGSEL_FORCE_RST    = 1'b0;
  localparam logic [2:0]  SGSEL_ACTIVE_RST   = 3'h0;
  localparam logic [7:0]  SGSEL_VEC_RST      = 8'h00;
  localparam logic [31:0] SGSEL_DATA_RST     = 32'h0000_0000;
  localparam logic [7:0]  SGSEL_ONLY_FIRST   = 8'h01;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SGSEL_CAUSE_RESET,
    SGSEL_CAUSE_AUTO,
    SGSEL_CAUSE_REMOTE,
    SGSEL_CAUSE_FORCE
  } sgsel_cause_t;

  typedef enum logic {
    SGSEL_BUS_IDLE,
    SGSEL_BUS_ANSWER
  } sgsel_bus_t;

  typedef struct packed {
    logic [2:0]   active;
    sgsel_cause_t cause;
  } sgsel_core_st_t;

  typedef struct packed {
    sgsel_bus_t   bus;
    logic         waitrequest;
    logic [31:0]  readdata;
    logic [2:0]   used_m1;
    logic         force_en;
    logic [7:0]   req;
    logic [7:0]   force_vec;
    logic [7:0]   remote_vec;
  } sgsel_main_st_t;

  // ----------------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------------
  // groups in use are always 1..n, so the mask is a thermometer code
  function automatic logic [7:0] sgsel_used_mask(input logic [2:0] used_m1);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < SGSEL_NUM_GROUPS; i++) begin
      m[i] = (3'(i) <= used_m1);
    end
    return m;
  endfunction

  // group number 1..8 to one-hot, 0 and 9..15 mean no group
  function automatic logic [7:0] sgsel_group_onehot(input logic [3:0] num);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < SGSEL_NUM_GROUPS; i++) begin
      v[i] = (num == 4'(i + 1));
    end
    return v;
  endfunction

endpackage

// [rtl/sgsel_top.sv]
// top: avalon-mm register front end, request capture and selector core
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module sgsel_top
  import sgsel_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        group_request_1,
  input  wire logic        group_request_2,
  input  wire logic        group_request_3,
  input  wire logic        group_request_4,
  input  wire logic        group_request_5,
  input  wire logic        group_request_6,
  input  wire logic        group_request_7,
  input  wire logic        group_request_8,
  output logic      [2:0]  active_group,
  output logic             force_change_enable
);

  // ----------------------------------------------------------------------
  // state and wiring
  // ----------------------------------------------------------------------
  sgsel_main_st_t st_r;
  sgsel_main_st_t st_nxt;
  sgsel_ctrl_if   ctl ();
  logic [7:0]     req_in;
  logic [31:0]    rd_word;

  assign req_in = {group_request_8, group_request_7, group_request_6, group_request_5,
                   group_request_4, group_request_3, group_request_2, group_request_1};

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = SGSEL_DATA_RST;
    if (avs_address == SGSEL_OFS_CONFIG) begin
      rd_word[SGSEL_CFG_USED_LSB +: 3] = st_r.used_m1;
      rd_word[SGSEL_CFG_FORCE_BIT]     = st_r.force_en;
    end else if (avs_address == SGSEL_OFS_STATUS) begin
      rd_word[SGSEL_ST_ACT_LSB +: 3]   = ctl.active;
      rd_word[SGSEL_ST_REQ_LSB +: 8]   = st_r.req;
      rd_word[SGSEL_ST_FORCE_BIT]      = st_r.force_en;
      rd_word[SGSEL_ST_CAUSE_LSB +: 2] = ctl.cause;
      rd_word[SGSEL_ST_USED_LSB +: 8]  = sgsel_used_mask(st_r.used_m1);
    end else begin
      // command registers and unmapped offsets read as zero
      rd_word = SGSEL_DATA_RST;
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt            = st_r;
    // command strobes live for one cycle only
    st_nxt.force_vec  = SGSEL_VEC_RST;
    st_nxt.remote_vec = SGSEL_VEC_RST;
    // inputs are synchronous; registering them keeps the core away from the pins
    st_nxt.req        = req_in;
    case (st_r.bus)
      SGSEL_BUS_IDLE: begin
        // answer one cycle after the request is seen
        if (avs_read || avs_write) begin
          st_nxt.bus         = SGSEL_BUS_ANSWER;
          st_nxt.waitrequest = 1'b0;
          if (avs_read) begin
            st_nxt.readdata = rd_word;
          end
        end
      end
      SGSEL_BUS_ANSWER: begin
        // this edge completes the transfer; writes take effect here
        st_nxt.bus         = SGSEL_BUS_IDLE;
        st_nxt.waitrequest = 1'b1;
        if (avs_write) begin
          if (avs_address == SGSEL_OFS_CONFIG) begin
            st_nxt.used_m1  = avs_writedata[SGSEL_CFG_USED_LSB +: 3];
            st_nxt.force_en = avs_writedata[SGSEL_CFG_FORCE_BIT];
          end else if (avs_address == SGSEL_OFS_FORCE) begin
            // a forced choice is a pulse and needs the override on
            if (st_r.force_en) begin
              st_nxt.force_vec = sgsel_group_onehot(avs_writedata[SGSEL_CMD_GRP_LSB +: 4]);
            end
          end else if (avs_address == SGSEL_OFS_REMOTE) begin
            // remote change competes as a one-cycle pulse at the rank of its group
            st_nxt.remote_vec = sgsel_group_onehot(avs_writedata[SGSEL_CMD_GRP_LSB +: 4]);
          end else begin
            // unmapped write: accepted and dropped
            st_nxt.remote_vec = SGSEL_VEC_RST;
          end
        end
      end
      default: begin
        st_nxt.bus         = SGSEL_BUS_IDLE;
        st_nxt.waitrequest = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.bus         <= SGSEL_BUS_IDLE;
      st_r.waitrequest <= 1'b1;
      st_r.readdata    <= SGSEL_DATA_RST;
      st_r.used_m1     <= SGSEL_USED_RST;
      st_r.force_en    <= SGSEL_FORCE_RST;
      st_r.req         <= SGSEL_VEC_RST;
      st_r.force_vec   <= SGSEL_VEC_RST;
      st_r.remote_vec  <= SGSEL_VEC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // selector core
  // ----------------------------------------------------------------------
  assign ctl.req_vec    = st_r.req;
  assign ctl.remote_vec = st_r.remote_vec;
  assign ctl.force_vec  = st_r.force_vec;
  assign ctl.used_mask  = sgsel_used_mask(st_r.used_m1);
  assign ctl.force_en   = st_r.force_en;

  sgsel_group_selector u_core (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ctl     (ctl)
  );

  // ----------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign avs_readdata        = st_r.readdata;
  assign avs_waitrequest     = st_r.waitrequest;
  assign active_group        = ctl.active;
  assign force_change_enable = st_r.force_en;

endmodule // sgsel_top

`default_nettype wire

// [tb/sgsel_chk.sv]
// checker: bus timing and group selection properties at the selector top ports
`timescale 1ns/100ps
`default_nettype none

module sgsel_chk
  import sgsel_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        group_request_1,
  input wire logic        group_request_2,
  input wire logic        group_request_3,
  input wire logic        group_request_4,
  input wire logic        group_request_5,
  input wire logic        group_request_6,
  input wire logic        group_request_7,
  input wire logic        group_request_8,
  input wire logic [2:0]  active_group,
  input wire logic        force_change_enable
);
  // shadow of groups in use; any write blocks the hold checks since its effect is not pinned
  logic [2:0] used_r;
  logic [2:0] used_nxt;
  logic       req_any;
  assign req_any = group_request_1 | group_request_2 | group_request_3 | group_request_4 |
                   group_request_5 | group_request_6 | group_request_7 | group_request_8;
  always_comb begin
    used_nxt = used_r;
    if (avs_write && !avs_waitrequest && avs_address == SGSEL_OFS_CONFIG) begin
      used_nxt = avs_writedata[2:0];
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      used_r <= SGSEL_USED_RST;
    end else begin
      used_r <= used_nxt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ans_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  // a pin or a completed write moves the group two edges later: input flop, then core
  hold_last_a: assert property (!req_any && !avs_write |-> ##2 $stable(active_group))
    else $error("active group moved without request");
  lvl_one_a: assert property (group_request_1 && !force_change_enable && !avs_write
    |-> ##2 (force_change_enable || active_group == 3'h0)) else $error("group 1 lost priority");
  lvl_two_a: assert property (group_request_2 && !group_request_1 && used_r != 3'h0
    && !force_change_enable && !avs_write |-> ##2 (force_change_enable || active_group == 3'h1))
    else $error("group 2 request not taken");
  force_hold_a: assert property (force_change_enable && !avs_write
    |-> ##2 (!force_change_enable || $stable(active_group)))
    else $error("override not holding");
  force_bit_a: assert property (avs_write && !avs_waitrequest && avs_address == SGSEL_OFS_CONFIG
    |=> force_change_enable == $past(avs_writedata[8]))
    else $error("override enable wrong");
  single_grp_a: assert property (used_r == 3'h0 && $past(used_r) == 3'h0
    |-> active_group == 3'h0) else $error("single group not held");
endmodule // sgsel_chk

bind sgsel_top sgsel_chk u_chk (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .group_request_1(group_request_1),
  .group_request_2(group_request_2), .group_request_3(group_request_3),
  .group_request_4(group_request_4), .group_request_5(group_request_5),
  .group_request_6(group_request_6), .group_request_7(group_request_7),
  .group_request_8(group_request_8), .active_group(active_group),
  .force_change_enable(force_change_enable));

`default_nettype wire

// [tb/sgsel_req_src.sv]
// partner model: internal logic and digital input sources of the group requests
`timescale 1ns/100ps
`default_nettype none

module sgsel_req_src (
  input  wire logic       mclk,
  output logic      [7:0] req_lines
);
  initial begin
    req_lines = 8'h00;
  end
  // one-cycle pulse, the shortest request a source can give
  task automatic pulse(input int g);
    req_lines[g-1] <= 1'b1;
    @(posedge mclk);
    req_lines[g-1] <= 1'b0;
  endtask
  // static level, held until the caller drops it
  task automatic level(input int g, input logic v);
    req_lines[g-1] <= v;
  endtask
endmodule // sgsel_req_src

`default_nettype wire

// [tb/tb.sv]
// testbench: register bus tasks and group selection sequences for the selector
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module tb;
  import sgsel_pkg::*;
  logic        mclk;
  logic        reset_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  req_lines;
  logic [2:0]  active_group;
  logic        force_change_enable;
  logic [31:0] rd;
  int          error_cnt;
  int          num_checks;

  sgsel_req_src src (.mclk(mclk), .req_lines(req_lines));
  sgsel_top dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .group_request_1(req_lines[0]), .group_request_2(req_lines[1]),
    .group_request_3(req_lines[2]), .group_request_4(req_lines[3]),
    .group_request_5(req_lines[4]), .group_request_6(req_lines[5]),
    .group_request_7(req_lines[6]), .group_request_8(req_lines[7]),
    .active_group(active_group), .force_change_enable(force_change_enable));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one transfer; an idle edge follows so no strobe is assigned twice in one step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    // the slave answers one cycle after taking the request
    `CHK(n, 2)
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic expect_grp(input logic [2:0] e);
    repeat (3) @(posedge mclk);
    `CHK(active_group, e)
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    end_sim;
  end

  initial begin
    reset_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    error_cnt = 0;
    num_checks = 0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    `CHK(active_group, 3'h0)
    `CHK(force_change_enable, 1'b0)
    src.pulse(3);
    expect_grp(3'h0);
    bus(1'b1, SGSEL_OFS_CONFIG, 32'h0000_0007);
    src.pulse(3);
    expect_grp(3'h2);
    repeat (10) @(posedge mclk);
    `CHK(active_group, 3'h2)
    bus(1'b0, SGSEL_OFS_STATUS, 32'h0);
    `CHK(rd[31:24], 8'hFF)
    for (int g = 8; g >= 1; g--) begin
      src.pulse(g);
      expect_grp(3'(g - 1));
    end
    src.level(4, 1'b1);
    src.level(2, 1'b1);
    expect_grp(3'h1);
    src.pulse(6);
    expect_grp(3'h1);
    bus(1'b1, SGSEL_OFS_REMOTE, 32'h0000_0007);
    expect_grp(3'h1);
    src.level(2, 1'b0);
    expect_grp(3'h3);
    src.level(1, 1'b1);
    src.level(6, 1'b1);
    bus(1'b1, SGSEL_OFS_REMOTE, 32'h0000_0002);
    expect_grp(3'h0);
    src.level(1, 1'b0);
    expect_grp(3'h3);
    src.level(6, 1'b0);
    src.level(4, 1'b0);
    // shrinking the in-use count below the active group falls back to group 1
    bus(1'b1, SGSEL_OFS_CONFIG, 32'h0000_0002);
    expect_grp(3'h0);
    src.pulse(5);
    expect_grp(3'h0);
    bus(1'b1, SGSEL_OFS_REMOTE, 32'h0000_0009);
    expect_grp(3'h0);
    bus(1'b1, SGSEL_OFS_REMOTE, 32'h0000_0003);
    expect_grp(3'h2);
    bus(1'b0, SGSEL_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0720_0002)
    bus(1'b1, SGSEL_OFS_FORCE, 32'h0000_0001);
    expect_grp(3'h2);
    bus(1'b1, SGSEL_OFS_CONFIG, 32'h0000_0102);
    `CHK(force_change_enable, 1'b1)
    bus(1'b0, SGSEL_OFS_CONFIG, 32'h0);
    `CHK(rd, 32'h0000_0102)
    bus(1'b1, SGSEL_OFS_FORCE, 32'h0000_0005);
    expect_grp(3'h2);
    bus(1'b1, SGSEL_OFS_FORCE, 32'h0000_0001);
    expect_grp(3'h0);
    bus(1'b0, SGSEL_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0731_0000)
    src.pulse(2);
    expect_grp(3'h0);
    bus(1'b1, SGSEL_OFS_REMOTE, 32'h0000_0002);
    expect_grp(3'h0);
    bus(1'b1, SGSEL_OFS_CONFIG, 32'h0000_0002);
    `CHK(force_change_enable, 1'b0)
    src.pulse(2);
    expect_grp(3'h1);
    bus(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, SGSEL_OFS_FORCE, 32'h0);
    `CHK(rd, 32'h0000_0000)
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(active_group, 3'h0)
    reset_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, SGSEL_OFS_CONFIG, 32'h0);
    `CHK(rd, 32'h0000_0000)
    end_sim;
  end
endmodule // tb

`default_nettype wire
